// ---- design/wgt_consts.svh ----
// register indices, field positions, reset values and timing constants of the guard timer
`ifndef WGT_CONSTS_SVH
`define WGT_CONSTS_SVH

// 0x93/0x94 are register indices, not byte offsets: byte address = 4*index
`define WGT_IDX_CONTROL 8'h93
`define WGT_IDX_RESTART 8'h94
`define WGT_IDX_STATUS 8'h95
`define WGT_IDX_MASK 8'h96
`define WGT_IDX_CAUSE 8'h97

`define WGT_BIT_ENABLE 7
`define WGT_BIT_NMI_SEL 6
`define WGT_BIT_RST_FLAG 5
`define WGT_BIT_NMI_FLAG 4
`define WGT_CLK_HI 3
`define WGT_CLK_LO 2
`define WGT_PER_HI 1
`define WGT_PER_LO 0

`define WGT_CLK_RESET 2'h2
`define WGT_CLK_SYS 2'h0
`define WGT_CLK_RTC 2'h1
`define WGT_CLK_RC 2'h2

`define WGT_KEY_FIRST 8'hA5
`define WGT_KEY_SECOND 8'h5A

`define WGT_LOG_PER0 27
`define WGT_LOG_PER1 25
`define WGT_LOG_PER2 22
`define WGT_LOG_PER3 18

// status and mask bit positions and width
`define WGT_EV_TIMEOUT 0
`define WGT_EV_KICK 1
`define WGT_EV_KEYERR 2
`define WGT_EV_W 3

// oscillator start-up time in microseconds, and its count at 20 MHz
`define WGT_RC_START_US 20000
`define WGT_CLK_MHZ 20
`define WGT_RC_START_CYC (`WGT_RC_START_US * `WGT_CLK_MHZ)

`endif

// ---- design/wgt_pkg.sv ----
// types shared by the guard timer design
package wgt_pkg;
  typedef enum logic [2:0] {
    WGT_IDLE = 3'b001,
    WGT_RUN = 3'b010,
    WGT_FIRE = 3'b100
  } wgt_state_t;
  typedef enum logic [1:0] {
    WGT_KEY_WAIT = 2'b01,
    WGT_KEY_ARMED = 2'b10
  } wgt_key_t;
endpackage

// ---- design/wgt_tick_sel.sv ----
// counting-clock selector: turns the chosen source into one-cycle ticks
`include "wgt_consts.svh"
module wgt_tick_sel #(
  parameter int RTC_DIV = 610,
  parameter int RC_DIV = 2000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic rc_ready,
  output logic tick
);
  initial begin
    if (RTC_DIV < 2 || RC_DIV < 2 || RTC_DIV > 65535 || RC_DIV > 65535) begin
      $error("wgt_tick_sel: divider out of range");
    end
  end

  logic [15:0] rtc_cnt;
  logic [15:0] rc_cnt;

  // the RTC divider runs free so switching sources does not restart its period; the RC divider holds at zero until rc_ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_cnt <= 16'h0000;
    end else if (rtc_cnt == 16'(RTC_DIV - 1)) begin
      rtc_cnt <= 16'h0000;
    end else begin
      rtc_cnt <= rtc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_cnt <= 16'h0000;
    end else if (!rc_ready || rc_cnt == 16'(RC_DIV - 1)) begin
      rc_cnt <= 16'h0000;
    end else begin
      rc_cnt <= rc_cnt + 16'h0001;
    end
  end

  // the reserved code yields no ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      unique case (sel)
        `WGT_CLK_SYS: tick <= 1'b1;
        `WGT_CLK_RTC: tick <= (rtc_cnt == 16'(RTC_DIV - 1));
        `WGT_CLK_RC: tick <= rc_ready && (rc_cnt == 16'(RC_DIV - 1));
        default: tick <= 1'b0;
      endcase
    end
  end
endmodule // wgt_tick_sel

// ---- design/wgt_guard_timer.sv ----
// guard timer core with Avalon-MM register slave
// Notes on behaviour
// - reset leaves timer disabled; writing one to control bit 7 enables it.
// - once enabled, every control register write is ignored until reset.
// - an enabled timer cannot be stopped by software, only by reset.
// - bits 1:0 choose period 2^27, 2^25, 2^22 or 2^18 ticks.
// - bits 3:2 choose system, real-time or RC clock; 11 reserved.
// - clock-source field resets to 10, the RC oscillator.
// - RC oscillator off only when deselected; about 20 ms to restart.
// - bit 6 zero resets chip on timeout, one raises nonmaskable interrupt.
// - bit 5 flags a reset timeout; cleared by external or debug reset.
// - bit 4 flags an interrupt timeout; cleared by other interrupt sources.
// - key A5h then 5Ah reloads the counter, which keeps counting.
// - any delay between keys allowed; timeout still fires if late.
// - a byte other than 5Ah after A5h discards the partial key.
//
// Chosen here: the Avalon-MM slave port.
`include "wgt_consts.svh"
module wgt_guard_timer #(
  parameter int RTC_DIV = 610,
  parameter int RC_DIV = 2000,
  parameter int RC_START_CYC = `WGT_RC_START_CYC,
  parameter int CNT_W = 28,
  parameter int RST_PULSE = 16,
  // period exponents; shorter values only to make time-outs reachable in sim
  parameter int LOG_PER0 = `WGT_LOG_PER0,
  parameter int LOG_PER1 = `WGT_LOG_PER1,
  parameter int LOG_PER2 = `WGT_LOG_PER2,
  parameter int LOG_PER3 = `WGT_LOG_PER3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic guard_reset_cause,
  input wire logic ext_nmi,
  output logic chip_reset_req,
  output logic cpu_nmi,
  output logic rc_osc_power,
  output logic irq
);
  initial begin
    if (CNT_W < 28 || CNT_W > 31 || RST_PULSE < 1 || RST_PULSE > 255 ||
        RC_START_CYC < 1 || LOG_PER0 < 1 || LOG_PER0 >= CNT_W ||
        LOG_PER1 < 1 || LOG_PER1 >= CNT_W || LOG_PER2 < 1 ||
        LOG_PER2 >= CNT_W || LOG_PER3 < 1 || LOG_PER3 >= CNT_W) begin
      $error("wgt_guard_timer: parameter out of range");
    end
  end

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  logic [7:0] idx;
  logic hit_ctl;
  logic hit_rr;
  logic hit_st;
  logic hit_msk;
  logic hit_cause;
  logic mapped;
  logic req;
  logic wr_go;
  logic rd_go;
  logic lane0;

  assign idx = avs_address[9:2];
  assign hit_ctl = (idx == `WGT_IDX_CONTROL);
  assign hit_rr = (idx == `WGT_IDX_RESTART);
  assign hit_st = (idx == `WGT_IDX_STATUS);
  assign hit_msk = (idx == `WGT_IDX_MASK);
  assign hit_cause = (idx == `WGT_IDX_CAUSE);
  assign mapped = hit_ctl | hit_rr | hit_st | hit_msk | hit_cause;
  assign req = avs_read | avs_write;
  assign lane0 = avs_byteenable[0];

  // one wait cycle: the answer comes on the second edge of each request
  logic ack;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end
  assign wr_go = avs_write && ack;
  assign rd_go = avs_read && ack;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && !ack);
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic enable;
  logic nmi_sel;
  logic [1:0] clk_sel;
  logic [1:0] per_sel;
  logic rst_flag;
  logic nmi_flag;
  logic ctl_wr;

  assign ctl_wr = wr_go && hit_ctl && lane0 && !enable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      nmi_sel <= 1'b0;
      clk_sel <= `WGT_CLK_RESET;
      per_sel <= 2'h0;
    end else if (ctl_wr) begin
      // enable only sets here; no path clears it before reset
      enable <= avs_writedata[`WGT_BIT_ENABLE];
      nmi_sel <= avs_writedata[`WGT_BIT_NMI_SEL];
      clk_sel <= avs_writedata[`WGT_CLK_HI:`WGT_CLK_LO];
      per_sel <= avs_writedata[`WGT_PER_HI:`WGT_PER_LO];
    end
  end

  // ---------------------------------------------------------------
  // oscillator power and start-up
  // ---------------------------------------------------------------
  // the oscillator runs while selected and stays off otherwise
  logic [31:0] rc_wait;
  logic rc_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_osc_power <= 1'b1;
    end else begin
      rc_osc_power <= (clk_sel == `WGT_CLK_RC);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_wait <= 32'h00000000;
    end else if (!rc_osc_power) begin
      rc_wait <= 32'h00000000;
    end else if (rc_wait != 32'(RC_START_CYC)) begin
      rc_wait <= rc_wait + 32'h00000001;
    end
  end
  assign rc_ready = rc_osc_power && (rc_wait == 32'(RC_START_CYC));

  logic tick;
  wgt_tick_sel #(
    .RTC_DIV(RTC_DIV),
    .RC_DIV(RC_DIV)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .sel(clk_sel),
    .rc_ready(rc_ready),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // restart key sequence
  // ---------------------------------------------------------------
  wgt_pkg::wgt_key_t key_state;
  logic kick;
  logic key_err;
  logic key_wr;
  logic [7:0] key_byte;

  assign key_wr = wr_go && hit_rr && lane0;
  assign key_byte = avs_writedata[7:0];
  assign kick = key_wr && (key_state == wgt_pkg::WGT_KEY_ARMED) &&
                (key_byte == `WGT_KEY_SECOND);
  assign key_err = key_wr && (key_state == wgt_pkg::WGT_KEY_ARMED) &&
                   (key_byte != `WGT_KEY_SECOND);

  // no time limit while armed: the counter alone decides lateness
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_state <= wgt_pkg::WGT_KEY_WAIT;
    end else if (key_wr) begin
      unique case (key_state)
        wgt_pkg::WGT_KEY_WAIT: begin
          if (key_byte == `WGT_KEY_FIRST) begin
            key_state <= wgt_pkg::WGT_KEY_ARMED;
          end
        end
        wgt_pkg::WGT_KEY_ARMED: begin
          key_state <= wgt_pkg::WGT_KEY_WAIT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // counter and time-out
  // ---------------------------------------------------------------
  wgt_pkg::wgt_state_t state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;
  logic timeout;
  logic [7:0] rst_cnt;

  always_comb begin
    unique case (per_sel)
      2'h0: limit = CNT_W'(1) << LOG_PER0;
      2'h1: limit = CNT_W'(1) << LOG_PER1;
      2'h2: limit = CNT_W'(1) << LOG_PER2;
      2'h3: limit = CNT_W'(1) << LOG_PER3;
    endcase
  end

  assign timeout = (state == wgt_pkg::WGT_RUN) && tick && !kick &&
                   (count == limit - CNT_W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= wgt_pkg::WGT_IDLE;
    end else begin
      unique case (state)
        wgt_pkg::WGT_IDLE: begin
          if (enable) begin
            state <= wgt_pkg::WGT_RUN;
          end
        end
        wgt_pkg::WGT_RUN: begin
          if (timeout && !nmi_sel) begin
            state <= wgt_pkg::WGT_FIRE;
          end
        end
        // holds the timer stopped until reset; the reset request itself ends after RST_PULSE cycles
        wgt_pkg::WGT_FIRE: state <= wgt_pkg::WGT_FIRE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (state != wgt_pkg::WGT_RUN || kick || timeout) begin
      count <= '0;
    end else if (tick) begin
      count <= count + CNT_W'(1);
    end
  end

  // reset request stretched so slow reset logic surely sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt <= 8'h00;
      chip_reset_req <= 1'b0;
    end else if (timeout && !nmi_sel) begin
      rst_cnt <= 8'(RST_PULSE);
      chip_reset_req <= 1'b1;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
      chip_reset_req <= (rst_cnt != 8'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_nmi <= 1'b0;
    end else begin
      cpu_nmi <= timeout && nmi_sel;
    end
  end

  // ---------------------------------------------------------------
  // cause flags
  // ---------------------------------------------------------------
  // the reset flag survives this block's own reset: the chip reset
  // logic reports on guard_reset_cause whether our time-out caused it
  logic cause_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_seen <= 1'b0;
      rst_flag <= 1'b0;
    end else if (!cause_seen) begin
      cause_seen <= 1'b1;
      rst_flag <= guard_reset_cause;
    end else if (timeout && !nmi_sel) begin
      rst_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_flag <= 1'b0;
    end else if (timeout && nmi_sel) begin
      nmi_flag <= 1'b1;
    end else if (ext_nmi) begin
      nmi_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // event status, mask and interrupt
  // ---------------------------------------------------------------
  logic [`WGT_EV_W-1:0] events;
  logic [`WGT_EV_W-1:0] status;
  logic [`WGT_EV_W-1:0] mask;
  logic st_rd;

  assign events = {key_err, kick, timeout};
  assign st_rd = rd_go && hit_st;

  // set wins over the clear-on-read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (st_rd ? '0 : status) | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (wr_go && hit_msk && lane0) begin
      mask <= avs_writedata[`WGT_EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((st_rd ? '0 : status) | events) & mask);
    end
  end

  // ---------------------------------------------------------------
  // read data and response
  // ---------------------------------------------------------------
  logic [7:0] ctl_view;
  assign ctl_view = {enable, nmi_sel, rst_flag, nmi_flag, clk_sel, per_sel};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if (req && !ack) begin
      avs_response <= mapped ? 2'h0 : 2'h3;
      if (!avs_read) begin
        avs_readdata <= 32'h00000000;
      end else if (hit_ctl) begin
        avs_readdata <= {24'h000000, ctl_view};
      end else if (hit_st) begin
        // include this cycle's events: the clear one edge later would
        // otherwise drop an event that was never shown
        avs_readdata <= {29'h00000000, status | events};
      end else if (hit_msk) begin
        avs_readdata <= {29'h00000000, mask};
      end else if (hit_cause) begin
        avs_readdata <= {28'h0000000, count[CNT_W-1:CNT_W-4]};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end
endmodule // wgt_guard_timer

// ---- sim/wgt_guard_timer_chk.sv ----
// checker for the guard timer bus handshake, lock and time-out outputs
`include "wgt_consts.svh"
module wgt_guard_timer_chk #(
  parameter int RST_PULSE = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic guard_reset_cause,
  input wire logic ext_nmi,
  input wire logic chip_reset_req,
  input wire logic cpu_nmi,
  input wire logic rc_osc_power,
  input wire logic irq
);
  logic en_seen;
  logic [7:0] lock_val;
  logic [1:0] clk_sel;
  int rst_len;
  wire [7:0] idx = avs_address[9:2];
  wire acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire acc_rd = avs_read && !avs_waitrequest;
  wire ctl_wr = acc_wr && idx == `WGT_IDX_CONTROL && !en_seen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // mirror of the control fields; frozen once enable has been taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_seen <= 1'b0;
      lock_val <= 8'h00;
      clk_sel <= `WGT_CLK_RESET;
    end else if (ctl_wr) begin
      en_seen <= avs_writedata[7];
      lock_val <= avs_writedata[7:0];
      clk_sel <= avs_writedata[3:2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_len <= 0;
    end else if (chip_reset_req) begin
      rst_len <= rst_len + 1;
    end else begin
      rst_len <= 0;
    end
  end

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer not after one wait cycle");
  a_wait_drop: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ctrl_locked: assert property (en_seen && acc_rd &&
    idx == `WGT_IDX_CONTROL |-> (avs_readdata[7:0] & 8'hCF) ==
    (lock_val & 8'hCF)) else $error("control changed after enable");
  a_nmi_gate: assert property (cpu_nmi |-> en_seen && lock_val[6])
    else $error("interrupt without enabled interrupt mode");
  a_reset_gate: assert property (chip_reset_req |->
    en_seen && !lock_val[6]) else $error("chip reset in wrong mode");
  a_nmi_pulse: assert property (cpu_nmi |=> !cpu_nmi)
    else $error("interrupt pulse longer than one cycle");
  a_rst_len: assert property ($fell(chip_reset_req) |->
    rst_len == RST_PULSE) else $error("chip reset pulse length wrong");
  a_decode_err: assert property (acc_rd && (idx < `WGT_IDX_CONTROL ||
    idx > `WGT_IDX_CAUSE) |-> avs_response == 2'h3 &&
    avs_readdata == 32'h0) else $error("unmapped read not refused");
  a_rc_power: assert property (clk_sel == 2'h2 ##1 clk_sel == 2'h2
    |-> rc_osc_power) else $error("oscillator off while selected");
endmodule // wgt_guard_timer_chk

bind wgt_guard_timer wgt_guard_timer_chk #(.RST_PULSE(RST_PULSE)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .guard_reset_cause(guard_reset_cause),
  .ext_nmi(ext_nmi), .chip_reset_req(chip_reset_req),
  .cpu_nmi(cpu_nmi), .rc_osc_power(rc_osc_power), .irq(irq));

// ---- sim/wgt_cpu_model.sv ----
// partner model: cpu interrupt source and chip reset bookkeeping
module wgt_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_reset_req,
  input wire logic ext_req,
  output logic guard_reset_cause,
  output logic ext_nmi
);
  logic seen = 1'b0;
  logic in_reset = 1'b0;
  initial guard_reset_cause = 1'b0;
  initial ext_nmi = 1'b0;
  // the cause is fixed once as reset begins and outlives it; a reset with
  // no request seen since the last one is an outside reset and wipes it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      if (!in_reset) begin
        guard_reset_cause <= seen || (chip_reset_req === 1'b1);
        seen <= 1'b0;
        in_reset <= 1'b1;
      end
    end else begin
      in_reset <= 1'b0;
      if (chip_reset_req === 1'b1) begin
        seen <= 1'b1;
      end
    end
  end
  always @(posedge clk) begin
    ext_nmi <= ext_req;
  end
endmodule // wgt_cpu_model

// ---- sim/tb.sv ----
// self-checking bench for the guard timer
`include "wgt_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [7:0] ix_ctl = `WGT_IDX_CONTROL;
  localparam logic [7:0] ix_key = `WGT_IDX_RESTART;
  localparam logic [7:0] ix_sts = `WGT_IDX_STATUS;
  localparam logic [7:0] ix_msk = `WGT_IDX_MASK;
  // short period exponents for codes 10 and 11 keep time-outs reachable
  localparam int lp2 = 11;
  localparam int lp3 = 9;
  time t0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic guard_reset_cause, ext_nmi, chip_reset_req, cpu_nmi;
  logic rc_osc_power, irq;
  logic ext_req = 1'b0;
  logic [31:0] rd;
  logic [1:0] rs;
  int fail_count = 0;
  int tests_run = 0;

  always #25 clk = ~clk;

  // short oscillator start-up keeps the run brief
  wgt_guard_timer #(.RC_START_CYC(10), .LOG_PER0(14), .LOG_PER1(13),
    .LOG_PER2(lp2), .LOG_PER3(lp3)) DUT (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .guard_reset_cause(guard_reset_cause),
    .ext_nmi(ext_nmi), .chip_reset_req(chip_reset_req),
    .cpu_nmi(cpu_nmi), .rc_osc_power(rc_osc_power), .irq(irq));
  wgt_cpu_model cpu (.clk(clk), .rst_n(rst_n),
    .chip_reset_req(chip_reset_req), .ext_req(ext_req),
    .guard_reset_cause(guard_reset_cause), .ext_nmi(ext_nmi));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
           input logic [3:0] be);
    @(posedge clk);
    avs_address <= {ix, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [7:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d, 4'hF);
  endtask

  task rdchk(input logic [7:0] ix, input logic [7:0] exp);
    bus(1'b0, ix, 8'h00, 4'hF);
    chk(rd, {24'h0, exp});
    chk({30'h0, rs}, 32'h0);
  endtask

  task settle;
    repeat (2) @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset_vals;
    rdchk(ix_ctl, 8'h08);
    chk({31'h0, rc_osc_power}, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask

  task t_fields;
    for (int i = 0; i < 4; i++) begin
      wr(ix_ctl, {4'h0, i[1:0], ~i[1:0]});
      rdchk(ix_ctl, {4'h0, i[1:0], ~i[1:0]});
      chk({31'h0, rc_osc_power}, {31'h0, i == 2});
    end
    bus(1'b1, ix_ctl, 8'h80, 4'hE);
    rdchk(ix_ctl, 8'h0C);
    bus(1'b0, 8'h10, 8'h00, 4'hF);
    chk({rd[31:2], rs}, 32'h3);
  endtask

  task t_lock;
    wr(ix_ctl, 8'h83);
    rdchk(ix_ctl, 8'h83);
    chk({31'h0, rc_osc_power}, 32'h0);
    wr(ix_ctl, 8'h00);
    rdchk(ix_ctl, 8'h83);
    wr(ix_ctl, 8'h4A);
    rdchk(ix_ctl, 8'h83);
  endtask

  task t_keys;
    wr(ix_msk, 8'h07);
    rdchk(ix_msk, 8'h07);
    wr(ix_key, 8'hA5);
    repeat (200) @(posedge clk);
    wr(ix_key, 8'h5A);
    settle;
    chk({31'h0, irq}, 32'h1);
    rdchk(ix_sts, 8'h02);
    settle;
    chk({31'h0, irq}, 32'h0);
    wr(ix_key, 8'hA5);
    wr(ix_key, 8'h33);
    wr(ix_key, 8'h5A);
    settle;
    rdchk(ix_sts, 8'h04);
  endtask

  task t_mask;
    wr(ix_msk, 8'h04);
    wr(ix_key, 8'hA5);
    wr(ix_key, 8'h5A);
    settle;
    chk({31'h0, irq}, 32'h0);
    rdchk(ix_sts, 8'h02);
    @(posedge clk);
    ext_req <= 1'b1;
    @(posedge clk);
    ext_req <= 1'b0;
    settle;
    rdchk(ix_ctl, 8'h83);
  endtask

  // reset-mode time-out with a key sequence left half done
  task t_late;
    wr(ix_key, 8'hA5);
    wr(ix_key, 8'h5A);
    t0 = $time;
    wr(ix_msk, 8'h01);
    wr(ix_key, 8'hA5);
    while (chip_reset_req !== 1'b1) @(posedge clk);
    // request launched at the last tick, seen one edge later
    chk(32'(($time - t0) / 50), (1 << lp3) + 1);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, cpu_nmi}, 32'h0);
    rdchk(ix_ctl, 8'hA3);
    repeat (20) @(posedge clk);
    chk({31'h0, chip_reset_req}, 32'h0);
  endtask

  task pulse_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task t_rereset;
    pulse_reset;
    rdchk(ix_ctl, 8'h28);
    pulse_reset;
    rdchk(ix_ctl, 8'h08);
  endtask

  // interrupt-mode time-outs repeat one period apart
  task t_nmi;
    wr(ix_ctl, 8'hC2);
    rdchk(ix_ctl, 8'hC2);
    while (cpu_nmi !== 1'b1) @(posedge clk);
    t0 = $time;
    chk({31'h0, chip_reset_req}, 32'h0);
    rdchk(ix_ctl, 8'hD2);
    @(posedge clk);
    ext_req <= 1'b1;
    @(posedge clk);
    ext_req <= 1'b0;
    settle;
    rdchk(ix_ctl, 8'hC2);
    do begin
      @(posedge clk);
    end while (cpu_nmi !== 1'b1);
    chk(32'(($time - t0) / 50), 1 << lp2);
  endtask

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_vals;
    t_fields;
    t_lock;
    t_keys;
    t_mask;
    t_late;
    t_rereset;
    t_nmi;
    final_report;
  end

  // the whole sequence needs about five thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule // tb
